// ===== ipmb_pkg.sv
// constants shared by the inter-processor message box files
// assumes a 9-bit word-aligned register address from one register port
package ipmb_pkg;

  // sizes
  localparam int unsigned NUM_QUEUES = 8;
  localparam int unsigned QUEUE_DEPTH = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned PEND_W = 16;
  localparam int unsigned COUNT_W = 3;
  localparam int unsigned NUM_USERS = 2;

  // register offsets (byte addresses)
  localparam logic [8:0] OFS_OWNER_LOW = 9'h000;
  localparam logic [8:0] OFS_OWNER_HIGH = 9'h004;
  localparam logic [8:0] OFS_IRQ_EN_BASE = 9'h040;
  localparam logic [8:0] OFS_IRQ_PEND_BASE = 9'h050;
  localparam logic [8:0] OFS_USER_STRIDE = 9'h020;
  localparam logic [8:0] OFS_FULL_BASE = 9'h100;
  localparam logic [8:0] OFS_COUNT_BASE = 9'h140;
  localparam logic [8:0] OFS_MSG_BASE = 9'h180;
  localparam logic [8:0] OFS_DEBUG = 9'h1c0;

  // field positions
  localparam int unsigned QUEUE_FIELD_STRIDE = 8;
  localparam int unsigned SENDER_BIT = 4;
  localparam int unsigned RECEIVER_BIT = 0;
  localparam int unsigned QUEUES_PER_CTRL = 4;
  localparam int unsigned DEBUG_MODE_BIT = 0;
  localparam int unsigned FIFO_CTRL_LSB = 8;

  // values after reset and writable masks
  localparam logic [31:0] OWNER_RST = 32'h1010_1010;
  localparam logic [31:0] OWNER_MASK = 32'h1111_1111;
  localparam logic [15:0] IRQ_EN_RST = 16'h0000;
  localparam logic [15:0] IRQ_PEND_RST = 16'haaaa;
  localparam logic [31:0] DEBUG_RST = 32'h0000_0000;
  localparam logic [31:0] DEBUG_MASK = 32'h0000_ff01;

endpackage : ipmb_pkg

// ===== ipmb_queue.sv
// one message queue: circular store, unread count, full flag, overwrite on full
// assumes push and pop come from a single register port, one request per cycle
`timescale 1ns/10ps
module ipmb_queue #(
  parameter int DATA_W = 32,
  parameter int DEPTH = 4,
  parameter int CNT_W = 3
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  ipmb_queue_if.queue q_if
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic [CNT_W-1:0] cap;
  logic do_pop;
  logic overwrite;
  logic grow;

  // capacity shrinks to one slot in debug single-register mode
  assign cap = q_if.single ? CNT_W'(1) : CNT_W'(DEPTH);
  assign q_if.full = (count_r >= cap);
  assign q_if.count = count_r;
  assign q_if.rdata = mem[rd_ptr_r];
  // a read of an empty queue removes nothing
  assign do_pop = q_if.pop && (count_r != '0);
  // full queue: drop the oldest instead of refusing the write
  assign overwrite = q_if.push && q_if.full && !do_pop;
  assign grow = q_if.push && !q_if.full && !do_pop;

  // count update, flush has priority
  always_comb
  begin
    count_nxt = count_r;
    if (q_if.flush)
      count_nxt = '0;
    else if (grow)
      count_nxt = count_r + CNT_W'(1);
    else if (do_pop && !q_if.push)
      count_nxt = count_r - CNT_W'(1);
  end

  // pointers and count
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || q_if.flush)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      count_r <= count_nxt;
      if (q_if.push)
        wr_ptr_r <= wr_ptr_r + PTR_W'(1);
      if (do_pop || overwrite)
        rd_ptr_r <= rd_ptr_r + PTR_W'(1);
    end
  end

  // message store, data needs no reset
  always_ff @(posedge i_sys_clk)
  begin
    if (q_if.push)
      mem[wr_ptr_r] <= q_if.wdata;
  end

  AST_COUNT_BOUND: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    count_r <= CNT_W'(DEPTH)) else $error("queue count above depth");
  AST_OVERWRITE_KEEPS_COUNT: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (overwrite && !q_if.flush) |=> (count_r == $past(count_r))
      && (rd_ptr_r == $past(rd_ptr_r) + PTR_W'(1)))
    else $error("overwrite of a full queue changed count or kept oldest");
  COV_OVERWRITE: cover property (@(posedge i_sys_clk) disable iff (i_reset) overwrite);
endmodule : ipmb_queue

// ===== ipmb_queue_if.sv
// request and status wires between the register front end and one queue
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface ipmb_queue_if #(
  parameter int DATA_W = 32,
  parameter int CNT_W = 3
);
  logic push;
  logic pop;
  logic flush;
  logic single;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [CNT_W-1:0] count;
  logic full;

  modport ctrl (output push, output pop, output flush, output single, output wdata,
                input rdata, input count, input full);
  modport queue (input push, input pop, input flush, input single, input wdata,
                 output rdata, output count, output full);
endinterface : ipmb_queue_if

// ===== ipmb_tb.sv
// self-checking bench: reset values, owner fields, queue traffic, pending and irq
// assumes the user model is the only driver of the register port
`timescale 1ns/10ps
module ipmb_tb;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic sel, wr, rvalid, irq0, irq1, rv;
  logic [8:0] addr;
  logic [31:0] wdata, rdata, rd, r, cnt, fs;
  logic [31:0] exp_q[8][$]; // reference queues
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n, qs;

  always #25 i_sys_clk = ~i_sys_clk;

  ipmb_top u_ipmb_top (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_reg_sel(sel), .i_reg_wr(wr),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .o_irq_user0(irq0), .o_irq_user1(irq1));
  ipmb_user_model u_ipmb_user_model (.i_sys_clk(i_sys_clk), .i_rdata(rdata),
    .i_rvalid(rvalid), .o_sel(sel), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  end
  endtask : chk_bit

  task automatic summarize;
  begin
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask : summarize

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge i_sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      summarize();
    end
  end

  task automatic rd_chk(input string what, input logic [8:0] a, input logic [31:0] exp);
  begin
    u_ipmb_user_model.access(1'b0, a, 32'h0, rd, rv);
    chk_bit("rvalid", 1'b1, rv);
    chk_word(what, exp, rd);
  end
  endtask : rd_chk

  task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
    u_ipmb_user_model.access(1'b1, a, d, rd, rv);
  endtask : wr_reg

  // push through the reference model; a fifth message drops the oldest
  task automatic push(input int q, input logic [31:0] m);
  begin
    u_ipmb_user_model.send(q, m, 1'b1, fs);
    chk_word("full", {31'h0, exp_q[q].size() == 4}, fs);
    exp_q[q].push_back(m);
    if (exp_q[q].size() > 4)
      void'(exp_q[q].pop_front());
    rd_chk("count", 9'h140 + 9'(4 * q), 32'(exp_q[q].size()));
  end
  endtask : push

  initial
  begin
    void'($urandom(32'ha751f216));
    repeat (8) @(negedge i_sys_clk);
    i_reset = 1'b0;
    // values straight after reset, plus a hole in the map
    rd_chk("owner_low", 9'h000, 32'h1010_1010);
    rd_chk("owner_high", 9'h004, 32'h1010_1010);
    for (int u = 0; u < 2; u++)
    begin
      rd_chk("irq_enable", 9'h040 + 9'(u * 32), 32'h0);
      rd_chk("irq_pending", 9'h050 + 9'(u * 32), 32'h0000_aaaa);
    end
    for (int k = 0; k < 8; k++)
      rd_chk("count", 9'h140 + 9'(4 * k), 32'h0);
    rd_chk("unmapped", 9'h0c0, 32'h0);
    // owner registers keep only their one-bit fields
    for (int k = 0; k < 4; k++)
    begin
      r = $urandom();
      wr_reg(9'(4 * (k % 2)), r);
      rd_chk("owner", 9'(4 * (k % 2)), r & 32'h1111_1111);
    end
    wr_reg(9'h000, 32'h1010_1010);
    wr_reg(9'h004, 32'h1010_1010);
    // random bursts, some past capacity, then drained oldest first
    for (int k = 0; k < 8; k++)
    begin
      n = 1 + $urandom_range(5);
      repeat (n) push(k, $urandom());
      while (exp_q[k].size() > 0)
      begin
        u_ipmb_user_model.recv(k, cnt, r);
        chk_word("count", 32'(exp_q[k].size()), cnt);
        chk_word("message", exp_q[k].pop_front(), r);
      end
      rd_chk("full", 9'h100 + 9'(4 * k), 32'h0);
    end
    // write-one clear; the sender's room bits come straight back
    wr_reg(9'h050, 32'h0000_ffff);
    rd_chk("pend0", 9'h050, 32'h0);
    wr_reg(9'h070, 32'h0000_ffff);
    rd_chk("pend1", 9'h070, 32'h0000_aaaa);
    // arrival interrupt to the receiver, enabled, kept by a zero write, then cleared
    qs = $urandom_range(7);
    wr_reg(9'h040, 32'(1) << (2 * qs));
    chk_bit("irq0", 1'b0, irq0);
    push(qs, $urandom());
    repeat (2) @(negedge i_sys_clk);
    chk_bit("irq0", 1'b1, irq0);
    wr_reg(9'h050, ~(32'(1) << (2 * qs)) & 32'h0000_ffff);
    rd_chk("pend0", 9'h050, 32'(1) << (2 * qs));
    wr_reg(9'h050, 32'(1) << (2 * qs));
    repeat (2) @(negedge i_sys_clk);
    chk_bit("irq0", 1'b0, irq0);
    // room interrupt to the sender
    wr_reg(9'h060, 32'(2) << (2 * qs));
    repeat (2) @(negedge i_sys_clk);
    chk_bit("irq1", 1'b1, irq1);
    wr_reg(9'h060, 32'h0);
    repeat (2) @(negedge i_sys_clk);
    chk_bit("irq1", 1'b0, irq1);
    // room bit re-arms while user0 sends on an unfilled queue 0
    wr_reg(9'h000, 32'h1010_1000);
    wr_reg(9'h050, 32'h0000_ffff);
    rd_chk("pend0", 9'h050, 32'h0000_0002);
    wr_reg(9'h000, 32'h1010_1010);
    // loopback: flush, one-slot queue, both users see the arrival
    r = 32'h0000_0001 | (32'h0000_0100 << qs);
    wr_reg(9'h1c0, r);
    exp_q[qs].delete();
    rd_chk("debug", 9'h1c0, r);
    rd_chk("count", 9'h140 + 9'(4 * qs), 32'h0);
    wr_reg(9'h070, 32'h0000_ffff);
    repeat (2)
    begin
      cnt = $urandom();
      wr_reg(9'h180 + 9'(4 * qs), cnt);
    end
    rd_chk("full", 9'h100 + 9'(4 * qs), 32'h1);
    rd_chk("count", 9'h140 + 9'(4 * qs), 32'h1);
    rd_chk("pend0", 9'h050, 32'h0000_aaaa | (32'h1 << (2 * qs)));
    rd_chk("pend1", 9'h070, 32'h0000_aaaa | (32'h1 << (2 * qs)));
    rd_chk("message", 9'h180 + 9'(4 * qs), cnt);
    rd_chk("count", 9'h140 + 9'(4 * qs), 32'h0);
    wr_reg(9'h1c0, 32'h0);
    summarize();
  end
endmodule : ipmb_tb

// ===== ipmb_top.sv
// two-user message box: owner control, per-user irq enable and pending,
// eight queues behind a word register port
// assumes the register port is driven by logic on i_sys_clk, one access per cycle
`timescale 1ns/10ps
module ipmb_top #(
  parameter int NUM_QUEUES = ipmb_pkg::NUM_QUEUES,
  parameter int QUEUE_DEPTH = ipmb_pkg::QUEUE_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_reg_sel,
  input wire logic i_reg_wr,
  input wire logic [ipmb_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [ipmb_pkg::DATA_W-1:0] i_reg_wdata,
  output logic [ipmb_pkg::DATA_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_irq_user0,
  output logic o_irq_user1
);
  localparam int DW = ipmb_pkg::DATA_W;
  localparam int CW = ipmb_pkg::COUNT_W;
  localparam int PW = ipmb_pkg::PEND_W;
  localparam int NU = ipmb_pkg::NUM_USERS;

  // control and status state
  logic [DW-1:0] owner_low_r;
  logic [DW-1:0] owner_high_r;
  logic [DW-1:0] debug_r;
  logic [NU-1:0][PW-1:0] irq_en_r;
  logic [NU-1:0][PW-1:0] pend_r;
  logic [NU-1:0][PW-1:0] pend_nxt;
  logic [NU-1:0][PW-1:0] pend_set;
  logic [NU-1:0][PW-1:0] pend_clr;
  logic [NU-1:0] irq_r;
  logic [NU-1:0] irq_nxt;
  logic [DW-1:0] rdata_r;
  logic [DW-1:0] rdata_nxt;
  logic rvalid_r;

  // per-queue views
  logic [NUM_QUEUES-1:0] q_full;
  logic [NUM_QUEUES-1:0] q_push;
  logic [NUM_QUEUES-1:0] sender_sel;
  logic [NUM_QUEUES-1:0] receiver_sel;
  logic [CW-1:0] q_count [NUM_QUEUES];
  logic [DW-1:0] q_rdata [NUM_QUEUES];

  // access decode
  wire wr_req = i_reg_sel && i_reg_wr;
  wire rd_req = i_reg_sel && !i_reg_wr;
  wire aligned = (i_reg_addr[1:0] == 2'h0);
  wire [2:0] q_idx = i_reg_addr[4:2];
  wire debug_mode = debug_r[ipmb_pkg::DEBUG_MODE_BIT];
  wire hit_owner_low = (i_reg_addr == ipmb_pkg::OFS_OWNER_LOW);
  wire hit_owner_high = (i_reg_addr == ipmb_pkg::OFS_OWNER_HIGH);
  wire hit_debug = (i_reg_addr == ipmb_pkg::OFS_DEBUG);
  // queue windows are 32 bytes wide, matched on the upper address bits
  wire hit_full = aligned && (i_reg_addr[8:5] == ipmb_pkg::OFS_FULL_BASE[8:5]);
  wire hit_count = aligned && (i_reg_addr[8:5] == ipmb_pkg::OFS_COUNT_BASE[8:5]);
  wire hit_msg = aligned && (i_reg_addr[8:5] == ipmb_pkg::OFS_MSG_BASE[8:5]);
  logic [NU-1:0] hit_en;
  logic [NU-1:0] hit_pend;

  // per-user address decode and pending sets
  genvar u;
  genvar q;
  generate
    for (u = 0; u < NU; u++)
    begin : g_user
      localparam logic [8:0] UOFS = 9'(u) * ipmb_pkg::OFS_USER_STRIDE;
      assign hit_en[u] = (i_reg_addr == ipmb_pkg::OFS_IRQ_EN_BASE + UOFS);
      assign hit_pend[u] = (i_reg_addr == ipmb_pkg::OFS_IRQ_PEND_BASE + UOFS);
      // write one clears, zero bits leave the flag alone
      assign pend_clr[u] = (wr_req && hit_pend[u]) ? i_reg_wdata[PW-1:0] : '0;
      // set beats clear so an event in the clearing cycle is kept
      assign pend_nxt[u] = (pend_r[u] & ~pend_clr[u]) | pend_set[u];
      assign irq_nxt[u] = |(pend_r[u] & irq_en_r[u]);
      for (q = 0; q < NUM_QUEUES; q++)
      begin : g_bit
        // debug mode lets each user talk to itself, so both see every event
        assign pend_set[u][2*q+1] = !q_full[q]
          && ((sender_sel[q] == 1'(u)) || debug_mode);
        assign pend_set[u][2*q] = q_push[q]
          && ((receiver_sel[q] == 1'(u)) || debug_mode);
      end
    end
  endgenerate

  // queues and their owner fields
  generate
    for (q = 0; q < NUM_QUEUES; q++)
    begin : g_queue
      localparam int FBASE = (q % ipmb_pkg::QUEUES_PER_CTRL) * ipmb_pkg::QUEUE_FIELD_STRIDE;
      ipmb_queue_if #(.DATA_W(DW), .CNT_W(CW)) q_if ();
      if (q < ipmb_pkg::QUEUES_PER_CTRL)
      begin : g_low
        assign sender_sel[q] = owner_low_r[FBASE + ipmb_pkg::SENDER_BIT];
        assign receiver_sel[q] = owner_low_r[FBASE + ipmb_pkg::RECEIVER_BIT];
      end
      else
      begin : g_high
        assign sender_sel[q] = owner_high_r[FBASE + ipmb_pkg::SENDER_BIT];
        assign receiver_sel[q] = owner_high_r[FBASE + ipmb_pkg::RECEIVER_BIT];
      end
      assign q_push[q] = wr_req && hit_msg && (q_idx == 3'(q));
      assign q_if.push = q_push[q];
      assign q_if.pop = rd_req && hit_msg && (q_idx == 3'(q));
      assign q_if.wdata = i_reg_wdata;
      // writing a one to a fifo-control bit empties that queue
      assign q_if.flush = wr_req && hit_debug && i_reg_wdata[ipmb_pkg::FIFO_CTRL_LSB + q];
      assign q_if.single = debug_r[ipmb_pkg::FIFO_CTRL_LSB + q];
      assign q_full[q] = q_if.full;
      assign q_count[q] = q_if.count;
      assign q_rdata[q] = q_if.rdata;
      ipmb_queue #(.DATA_W(DW), .DEPTH(QUEUE_DEPTH), .CNT_W(CW)) u_queue (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .q_if(q_if.queue)
      );
    end
  endgenerate

  // read mux, unmapped and reserved bits read zero
  assign rdata_nxt =
    hit_owner_low ? owner_low_r :
    hit_owner_high ? owner_high_r :
    hit_en[0] ? {16'h0000, irq_en_r[0]} :
    hit_en[1] ? {16'h0000, irq_en_r[1]} :
    hit_pend[0] ? {16'h0000, pend_r[0]} :
    hit_pend[1] ? {16'h0000, pend_r[1]} :
    hit_full ? {31'h0000_0000, q_full[q_idx]} :
    hit_count ? {29'h0000_0000, q_count[q_idx]} :
    hit_msg ? q_rdata[q_idx] :
    hit_debug ? debug_r : 32'h0000_0000;

  // owner, debug and enable registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      owner_low_r <= ipmb_pkg::OWNER_RST;
      owner_high_r <= ipmb_pkg::OWNER_RST;
      debug_r <= ipmb_pkg::DEBUG_RST;
      irq_en_r <= {NU{ipmb_pkg::IRQ_EN_RST}};
    end
    else
    begin
      if (wr_req && hit_owner_low)
        owner_low_r <= i_reg_wdata & ipmb_pkg::OWNER_MASK;
      if (wr_req && hit_owner_high)
        owner_high_r <= i_reg_wdata & ipmb_pkg::OWNER_MASK;
      if (wr_req && hit_debug)
        debug_r <= i_reg_wdata & ipmb_pkg::DEBUG_MASK;
      for (int i = 0; i < NU; i++)
        if (wr_req && hit_en[i])
          irq_en_r[i] <= i_reg_wdata[PW-1:0];
    end
  end

  // pending flags and interrupt outputs
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      pend_r <= {NU{ipmb_pkg::IRQ_PEND_RST}};
      irq_r <= '0;
    end
    else
    begin
      pend_r <= pend_nxt;
      irq_r <= irq_nxt;
    end
  end

  // read data one cycle after the request; a message read pops in that edge
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= rd_req;
      if (rd_req)
        rdata_r <= rdata_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_reg_rvalid = rvalid_r;
  assign o_irq_user0 = irq_r[0];
  assign o_irq_user1 = irq_r[1];

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  // helper views on queue 0 and user 0
  wire msg_rd0 = rd_req && hit_msg && (q_idx == 3'h0);
  wire msg_wr0 = wr_req && hit_msg && (q_idx == 3'h0);
  wire pend_wr0 = wr_req && hit_pend[0];

  AST_OWNER_RESET: assert property ($past(i_reset) |->
    (owner_low_r == 32'h1010_1010) && (owner_high_r == 32'h1010_1010)
      && (pend_r[0] == 16'haaaa))
    else $error("owner or pending value wrong after reset");
  AST_SPACE_PEND: assert property ((!q_full[3] && sender_sel[3] && !debug_mode)
    |=> pend_r[1][7])
    else $error("space pending not set for sender of queue 3");
  AST_ARRIVAL_PEND: assert property ((q_push[5] && !receiver_sel[5])
    |=> pend_r[0][10])
    else $error("arrival pending not set for receiver of queue 5");
  AST_W1C_CLEARS: assert property ((pend_wr0 && i_reg_wdata[0] && !pend_set[0][0])
    |=> !pend_r[0][0])
    else $error("write one did not clear pending");
  AST_W0_KEEPS: assert property ((pend_wr0 && !i_reg_wdata[0] && pend_r[0][0])
    |=> pend_r[0][0])
    else $error("write zero changed pending");
  AST_IRQ_FOLLOWS: assert property (((pend_r[1] & irq_en_r[1]) != '0)
    |=> o_irq_user1)
    else $error("user1 interrupt missing while enabled pending");
  AST_NO_IRQ_WITHOUT_ENABLE: assert property ((irq_en_r[0] == '0) |=> !o_irq_user0)
    else $error("user0 interrupt with all enables off");
  AST_FULL_AT_FOUR: assert property (!debug_r[8] |->
    (q_full[0] == (q_count[0] == 3'h4)))
    else $error("full flag disagrees with count on queue 0");
  AST_POP_DECREMENTS: assert property ((msg_rd0 && q_count[0] != 3'h0)
    |=> (q_count[0] == $past(q_count[0]) - 3'h1) ##0 o_reg_rvalid)
    else $error("message read did not remove one message");
  AST_PUSH_INCREMENTS: assert property ((msg_wr0 && !q_full[0])
    |=> (q_count[0] == $past(q_count[0]) + 3'h1))
    else $error("message write not appended");
  AST_SPACE_REARM: assert property ((pend_wr0 && i_reg_wdata[1] && !q_full[0]
    && !sender_sel[0]) |=> pend_r[0][1])
    else $error("space pending not re-set after clear");

  // owner writes land in the queue's sender and receiver views
  AST_SENDER_FROM_LOW: assert property ((wr_req && hit_owner_low)
    |=> (sender_sel[1] == $past(i_reg_wdata[12])))
    else $error("queue 1 sender not taken from low control");
  AST_RECEIVER_FROM_HIGH: assert property ((wr_req && hit_owner_high)
    |=> (receiver_sel[6] == $past(i_reg_wdata[16])))
    else $error("queue 6 receiver not taken from high control");
  AST_OWNER_FIELDS_ONLY: assert property ((wr_req && hit_owner_low)
    |=> (owner_low_r == ($past(i_reg_wdata) & 32'h1111_1111)))
    else $error("low control kept bits outside the owner fields");

  // interrupt enables and arrival routing
  AST_ENABLE_RESET: assert property ($past(i_reset) |-> (irq_en_r == '0))
    else $error("interrupt enables not cleared by reset");
  AST_ARRIVAL_IRQ: assert property (((pend_r[0] & irq_en_r[0] & 16'h5555) != '0)
    |=> o_irq_user0)
    else $error("enabled arrival pending gave no user0 interrupt");
  // loopback mode routes the room event to both users
  AST_LOOPBACK_SPACE: assert property ((debug_mode && !q_full[2]) |=> pend_r[0][5])
    else $error("loopback room pending missing for user0");
  // read path: data one edge after the request
  AST_READ_ANSWER: assert property (rd_req |=> o_reg_rvalid)
    else $error("read request without a data pulse");
  AST_FULL_WORD: assert property ((rd_req && hit_full && q_idx == 3'h2)
    |=> (o_reg_rdata == {31'h0000_0000, $past(q_full[2])}))
    else $error("full word does not show queue 2 full flag");
  AST_COUNT_WORD: assert property ((rd_req && hit_count && q_idx == 3'h1)
    |=> (o_reg_rdata == {29'h0000_0000, $past(q_count[1])}))
    else $error("count word does not show queue 1 count");
  AST_OLDEST_OUT: assert property ((msg_rd0 && q_count[0] != 3'h0)
    |=> (o_reg_rdata == $past(q_rdata[0])))
    else $error("message read did not return the oldest entry");
  AST_FULL_OVERWRITE: assert property ((msg_wr0 && q_full[0])
    |=> q_full[0] && (q_count[0] == $past(q_count[0])))
    else $error("write to full queue 0 changed its level");

  COV_QUEUE_FULL: cover property (q_full[0] && q_count[0] == 3'h4);
  COV_LOOPBACK_PUSH: cover property (debug_mode && (q_push != '0));
  COV_IRQ_USER0: cover property ($rose(o_irq_user0));
  COV_READ_AFTER_FILL: cover property (q_full[4] ##[1:20] (rd_req && hit_msg && q_idx == 3'h4));
endmodule : ipmb_top

// ===== ipmb_user_model.sv
// stand-in for the two processors that share the message box register port
// assumes one access at a time, launched and released on falling edges
`timescale 1ns/10ps
module ipmb_user_model (
  input wire logic i_sys_clk,
  input wire logic [31:0] i_rdata,
  input wire logic i_rvalid,
  output logic o_sel,
  output logic o_wr,
  output logic [8:0] o_addr,
  output logic [31:0] o_wdata
);
  // idle port at time zero
  initial
  begin
    o_sel = 1'b0;
    o_wr = 1'b0;
    o_addr = 9'h1ff;
    o_wdata = 32'h0;
  end

  // one word access; the request spans exactly one rising edge
  task automatic access(input logic wr, input logic [8:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic rv);
  begin
    @(negedge i_sys_clk);
    o_sel = 1'b1;
    o_wr = wr;
    o_addr = addr;
    o_wdata = wdata;
    @(negedge i_sys_clk);
    o_sel = 1'b0;
    o_addr = ~addr; // released address and data lines never keep the last value; o_wr does
    o_wdata = ~wdata;
    rdata = i_rdata;
    rv = i_rvalid;
  end
  endtask : access

  // check the full word first; push only with room unless told to overwrite
  task automatic send(input int q, input logic [31:0] msg, input logic force_push,
                      output logic [31:0] full_word);
    logic rv;
    logic [31:0] dummy;
  begin
    access(1'b0, 9'h100 + 9'(4 * q), 32'h0, full_word, rv);
    if (full_word[0] == 1'b0 || force_push)
      access(1'b1, 9'h180 + 9'(4 * q), msg, dummy, rv);
  end
  endtask : send

  // poll the unread count, read the port once something is there
  task automatic recv(input int q, output logic [31:0] cnt, output logic [31:0] msg);
    logic rv;
  begin
    cnt = 32'h0;
    for (int i = 0; i < 16 && cnt == 32'h0; i++)
      access(1'b0, 9'h140 + 9'(4 * q), 32'h0, cnt, rv);
    access(1'b0, 9'h180 + 9'(4 * q), 32'h0, msg, rv);
  end
  endtask : recv
endmodule : ipmb_user_model
